// >>> dmam_pkg.sv
/*
 * dmam_pkg: shared types, register map and field layout of the data memory
 * address modifier.
 * assumes: compiled before every other file of the block.
 */
package dmam_pkg;

	// address layout: bank[10:7] row[6:4] column[3:0]
	localparam int ADDR_W = 11;
	localparam int BANK_W = 4;
	localparam int ROW_W  = 3;
	localparam int COL_W  = 4;
	localparam int COL_LSB  = 0;
	localparam int ROW_LSB  = 4;
	localparam int BANK_LSB = 7;

	// index register fields
	localparam int IDX_LOW_LSB  = 0;
	localparam int IDX_MID_LSB  = 4;
	localparam int IDX_HIGH_LSB = 8;
	localparam int IDX_HIGH_W   = 3;

	// row pointer fields
	localparam int PTR_LOW_W  = 4;
	localparam int PTR_HIGH_W = 3;
	localparam int PTR_W      = 7;

	// axi4-lite register byte offsets
	localparam logic [7:0] OFF_INDEX  = 8'h00;
	localparam logic [7:0] OFF_PTR    = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;

	// ctrl bit positions
	localparam int CTRL_INDEX_EN = 0;
	localparam int CTRL_PTR_EN   = 1;

	// the enable flag keeps this address unmodified
	localparam logic [10:0] FLAG_ADDR = 11'h07f;

	// reset values
	localparam logic [10:0] INDEX_RST = 11'h000;
	localparam logic [6:0]  PTR_RST   = 7'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {
		DMAM_OP_DIRECT,    // arithmetic, logic, skips, load, store, immediate
		DMAM_OP_IND_TO_R,  // transfer m to @r
		DMAM_OP_IND_FROM_R,// transfer @r to m
		DMAM_OP_NONE
	} dmam_op_t;

	typedef struct packed {
		logic [3:0] bank;
		logic [2:0] row;
		logic [3:0] col;
	} dmam_addr_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] kind;
		logic [2:0] operand_row;
		logic [3:0] operand_column;
		logic [3:0] gen_reg_data;
	} dmam_req_t;

	typedef struct packed {
		logic       valid;
		dmam_addr_t direct;
		dmam_addr_t indirect;
		logic       ind_used;
	} dmam_res_t;

	function automatic dmam_addr_t dmam_split(input logic [10:0] a);
		dmam_split = dmam_addr_t'(a);
	endfunction

endpackage

// >>> dmam_axil.sv
/*
 * dmam_axil: axi4-lite slave for the index register, row pointer, control
 * and status words of the address modifier.
 * assumes: single clock, synchronous active-high reset, one access of each
 * kind at a time from the master.
 */
`timescale 1ns/10ps
module dmam_axil
	import dmam_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	input  wire logic [31:0] status_i,
	output logic             wr_o,
	output logic [7:0]       wr_addr_o,
	output logic [31:0]      wr_data_o
);
	typedef struct packed {
		logic        aw_ok;
		logic [7:0]  aw;
		logic        w_ok;
		logic [31:0] w;
		logic [3:0]  s;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dmam_bus_t;

	dmam_bus_t st_reg;
	dmam_bus_t st_next;
	logic      fire;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFF_INDEX) || (a == OFF_PTR) ||
			(a == OFF_CTRL) || (a == OFF_STATUS);
	endfunction

	assign awready_o = !st_reg.aw_ok && !st_reg.bvalid;
	assign wready_o  = !st_reg.w_ok && !st_reg.bvalid;
	assign arready_o = !st_reg.rvalid;
	assign fire      = st_reg.aw_ok && st_reg.w_ok;

	always_comb begin
		st_next = st_reg;
		if (awvalid_i && awready_o) begin
			st_next.aw_ok = 1'b1;
			st_next.aw    = awaddr_i;
		end
		if (wvalid_i && wready_o) begin
			st_next.w_ok = 1'b1;
			st_next.w    = wdata_i;
			st_next.s    = wstrb_i;
		end
		if (fire) begin
			st_next.aw_ok  = 1'b0;
			st_next.w_ok   = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = mapped(st_reg.aw) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.bvalid && bready_i)
			st_next.bvalid = 1'b0;
		if (arvalid_i && arready_o) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = status_i;
			st_next.rresp  = mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.rvalid && rready_i)
			st_next.rvalid = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// the top passes the addressed word in through status_i by read address
	assign wr_o      = fire && mapped(st_reg.aw) && st_reg.s[0];
	assign wr_addr_o = st_reg.aw;
	assign wr_data_o = st_reg.w;
	assign bvalid_o  = st_reg.bvalid;
	assign bresp_o   = st_reg.bresp;
	assign rvalid_o  = st_reg.rvalid;
	assign rdata_o   = st_reg.rdata;
	assign rresp_o   = st_reg.rresp;
endmodule

// >>> dmam_calc.sv
/*
 * dmam_calc: combinational address former. Takes the encoded operand, the
 * bank, the general register contents and the two enable flags and gives the
 * direct and indirect addresses.
 * assumes: caller registers the result.
 */
`timescale 1ns/10ps
module dmam_calc
	import dmam_pkg::*;
(
	input  wire logic [3:0]  bank_i,
	input  wire logic [2:0]  operand_row_i,
	input  wire logic [3:0]  operand_column_i,
	input  wire logic [3:0]  gen_reg_data_i,
	input  wire logic [1:0]  kind_i,
	input  wire logic [10:0] index_reg_i,
	input  wire logic [6:0]  row_pointer_i,
	input  wire logic        index_mod_enable_i,
	input  wire logic        pointer_enable_i,
	output dmam_addr_t       direct_o,
	output dmam_addr_t       indirect_o,
	output logic             ind_used_o
);
	logic [10:0] raw;
	logic [10:0] dir;
	logic        ind;

	always_comb begin
		raw = {bank_i, operand_row_i, operand_column_i};
		ind = (kind_i == 2'(DMAM_OP_IND_TO_R)) ||
			(kind_i == 2'(DMAM_OP_IND_FROM_R));
		dir = raw;
		if (index_mod_enable_i && !pointer_enable_i &&
			raw != FLAG_ADDR)
			dir = raw | index_reg_i;
		direct_o = dmam_split(dir);
		indirect_o = dmam_split(dir);
		indirect_o.col = gen_reg_data_i;
		if (pointer_enable_i && !index_mod_enable_i) begin
			direct_o = dmam_split(raw);
			// pointer lines up with address bits 10:4, like the index
			indirect_o.bank = row_pointer_i[6:3];
			indirect_o.row  = row_pointer_i[2:0];
		end
		ind_used_o = ind;
	end
endmodule

// >>> dmam_top.sv
/*
 * dmam_top: data memory address modifier of a 4-bit core.
 * assumes: the core presents one request per instruction on REQ_I and
 * reads the registered addresses the next cycle; software sets the
 * index register, row pointer and enables over axi4-lite.
 */
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module dmam_top
	import dmam_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	input  wire logic [3:0]  BANK_I,
	input  wire logic [2:0]  GEN_REG_ROW_SELECT_I,
	input  wire dmam_req_t   REQ_I,
	output dmam_res_t        RES_O,
	output logic [10:0]      GEN_REG_ADDR_O,
	output logic             ADD_RESULT_TO_R_O
);
	typedef struct packed {
		logic [10:0] index_reg;
		logic [6:0]  row_pointer;
		logic        index_mod_enable;
		logic        pointer_enable;
		dmam_res_t   res;
		logic [10:0] gen_reg_addr;
		logic        add_to_r;
	} dmam_state_t;

	dmam_state_t st_reg;
	dmam_state_t st_next;
	dmam_addr_t  dir_w;
	dmam_addr_t  ind_w;
	logic        ind_used_w;
	logic        wr_w;
	logic [7:0]  wr_addr_w;
	logic [31:0] wr_data_w;
	logic [31:0] rd_word;
	logic [7:0]  bus_aw_w;

	dmam_axil u_bus (
		.clk_i            (CLK_I),
		.rst_i            (RST_I),
		.awaddr_i         (AWADDR_I),
		.awvalid_i        (AWVALID_I),
		.awready_o        (AWREADY_O),
		.wdata_i          (WDATA_I),
		.wstrb_i          (WSTRB_I),
		.wvalid_i         (WVALID_I),
		.wready_o         (WREADY_O),
		.bresp_o          (BRESP_O),
		.bvalid_o         (BVALID_O),
		.bready_i         (BREADY_I),
		.araddr_i         (ARADDR_I),
		.arvalid_i        (ARVALID_I),
		.arready_o        (ARREADY_O),
		.rdata_o          (RDATA_O),
		.rresp_o          (RRESP_O),
		.rvalid_o         (RVALID_O),
		.rready_i         (RREADY_I),
		.status_i         (rd_word),
		.wr_o             (wr_w),
		.wr_addr_o        (wr_addr_w),
		.wr_data_o        (wr_data_w)
	);

	// enables come from registered flags, so a write lands for the next op
	dmam_calc u_calc (
		.bank_i             (BANK_I),
		.operand_row_i      (REQ_I.operand_row),
		.operand_column_i   (REQ_I.operand_column),
		.gen_reg_data_i     (REQ_I.gen_reg_data),
		.kind_i             (REQ_I.kind),
		.index_reg_i        (st_reg.index_reg),
		.row_pointer_i      (st_reg.row_pointer),
		.index_mod_enable_i (st_reg.index_mod_enable),
		.pointer_enable_i   (st_reg.pointer_enable),
		.direct_o           (dir_w),
		.indirect_o         (ind_w),
		.ind_used_o         (ind_used_w)
	);

	assign bus_aw_w = wr_addr_w;

	// read mux is combinational on the araddr; the slave registers it
	always_comb begin
		case (ARADDR_I)
			OFF_INDEX:  rd_word = {21'h0, st_reg.index_reg};
			OFF_PTR:    rd_word = {25'h0, st_reg.row_pointer};
			OFF_CTRL:   rd_word = {30'h0, st_reg.pointer_enable,
				st_reg.index_mod_enable};
			OFF_STATUS: rd_word = {21'h0, st_reg.res.direct};
			default:    rd_word = 32'h00000000;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		if (wr_w) begin
			case (bus_aw_w)
				OFF_INDEX: begin
					st_next.index_reg = wr_data_w[10:0];
				end
				OFF_PTR: begin
					st_next.row_pointer = wr_data_w[6:0];
				end
				OFF_CTRL: begin
					// both set is prohibited; the index flag then wins off
					st_next.index_mod_enable = wr_data_w[CTRL_INDEX_EN] &&
						!wr_data_w[CTRL_PTR_EN];
					st_next.pointer_enable = wr_data_w[CTRL_PTR_EN];
				end
				default: begin
					st_next.index_reg = st_reg.index_reg;
				end
			endcase
		end
		st_next.res.valid    = REQ_I.valid;
		st_next.res.direct   = dir_w;
		st_next.res.indirect = ind_w;
		st_next.res.ind_used = ind_used_w && REQ_I.valid;
		st_next.gen_reg_addr = {BANK_I, GEN_REG_ROW_SELECT_I,
			REQ_I.operand_column};
		st_next.add_to_r = REQ_I.valid &&
			REQ_I.kind == 2'(DMAM_OP_DIRECT);
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st_reg             <= '0;
			st_reg.index_reg   <= INDEX_RST;
			st_reg.row_pointer <= PTR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RES_O             = st_reg.res;
	assign GEN_REG_ADDR_O    = st_reg.gen_reg_addr;
	assign ADD_RESULT_TO_R_O = st_reg.add_to_r;

	plain_off_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && !st_reg.index_mod_enable && !st_reg.pointer_enable)
		|=> RES_O.direct == {$past(BANK_I), $past(REQ_I.operand_row),
			$past(REQ_I.operand_column)})
		else $error("unmodified address changed");
	index_or_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.index_mod_enable &&
		{BANK_I, REQ_I.operand_row, REQ_I.operand_column} != FLAG_ADDR)
		|=> RES_O.direct == ({$past(BANK_I), $past(REQ_I.operand_row),
			$past(REQ_I.operand_column)} | $past(st_reg.index_reg)))
		else $error("index or missing");
	flag_keep_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && {BANK_I, REQ_I.operand_row,
		REQ_I.operand_column} == FLAG_ADDR)
		|=> RES_O.direct == FLAG_ADDR)
		else $error("flag address modified");
	diag_row_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.pointer_enable && !st_reg.index_mod_enable)
		|=> RES_O.indirect.row == $past(st_reg.row_pointer[2:0]))
		else $error("diagonal row wrong");
	ind_col_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		REQ_I.valid |=> RES_O.indirect.col == $past(REQ_I.gen_reg_data))
		else $error("indirect column wrong");
	horiz_row_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && !st_reg.pointer_enable)
		|=> RES_O.indirect.row == RES_O.direct.row)
		else $error("horizontal row differs");
	diag_direct_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.pointer_enable)
		|=> RES_O.direct.col == $past(REQ_I.operand_column))
		else $error("direct modified in diagonal");
	ind_or_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.index_mod_enable)
		|=> (RES_O.indirect.row & $past(st_reg.index_reg[6:4]))
			== $past(st_reg.index_reg[6:4]))
		else $error("indirect row not ored");
	flags_excl_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		!(st_reg.index_mod_enable && st_reg.pointer_enable))
		else $error("prohibited enable pair");

	plain_ind_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && !st_reg.index_mod_enable && !st_reg.pointer_enable)
		|=> {RES_O.indirect.bank, RES_O.indirect.row} ==
			{$past(BANK_I), $past(REQ_I.operand_row)})
		else $error("horizontal bank or row wrong");
	diag_bank_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.pointer_enable && !st_reg.index_mod_enable)
		|=> RES_O.indirect.bank == $past(st_reg.row_pointer[6:3]))
		else $error("diagonal bank wrong");
	ind_bank_or_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.index_mod_enable &&
		{BANK_I, REQ_I.operand_row, REQ_I.operand_column} != FLAG_ADDR)
		|=> RES_O.indirect.bank ==
			($past(BANK_I) | $past(st_reg.index_reg[10:7])))
		else $error("indirect bank not ored");
	diag_whole_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		(REQ_I.valid && st_reg.pointer_enable)
		|=> RES_O.direct == {$past(BANK_I), $past(REQ_I.operand_row),
			$past(REQ_I.operand_column)})
		else $error("diagonal direct address modified");
	ind_kind_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		REQ_I.valid |=> RES_O.ind_used ==
			($past(REQ_I.kind) == 2'(DMAM_OP_IND_TO_R) ||
			$past(REQ_I.kind) == 2'(DMAM_OP_IND_FROM_R)))
		else $error("indirect use flag wrong");
	idle_out_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		!REQ_I.valid |=> !RES_O.valid && !RES_O.ind_used &&
			!ADD_RESULT_TO_R_O)
		else $error("result without request");
	add_back_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		REQ_I.valid |=> ADD_RESULT_TO_R_O ==
			($past(REQ_I.kind) == 2'(DMAM_OP_DIRECT)))
		else $error("write back flag wrong");
	gen_row_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		REQ_I.valid |=>
			GEN_REG_ADDR_O[6:4] == $past(GEN_REG_ROW_SELECT_I))
		else $error("general register row wrong");
	flag_hold_a: assert property (@(posedge CLK_I)
		disable iff (RST_I)
		!wr_w |=>
			$stable({st_reg.index_mod_enable, st_reg.pointer_enable}))
		else $error("enable changed without write");
endmodule

// >>> dmam_top_test.sv
/*
 * dmam_top_test: self-checking bench of the data memory address modifier.
 * assumes: dmam_pkg and the design files are compiled first; the bench
 * alone drives the register bus and the core request port.
 */
`timescale 1ns/10ps
module dmam_top_test
	import dmam_pkg::*;
;
	logic        CLK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I;
	logic        ARVALID_I, RREADY_I, AWREADY_O, WREADY_O, BVALID_O;
	logic        ARREADY_O, RVALID_O, ADD_RESULT_TO_R_O;
	logic [7:0]  AWADDR_I, ARADDR_I;
	logic [31:0] WDATA_I, RDATA_O, rd;
	logic [3:0]  WSTRB_I, BANK_I;
	logic [2:0]  GEN_REG_ROW_SELECT_I;
	logic [1:0]  BRESP_O, RRESP_O, rs;
	logic [10:0] GEN_REG_ADDR_O;
	dmam_req_t   REQ_I;
	dmam_res_t   RES_O;
	int          n_fail, num_checks;

	dmam_top i_dut (
		.CLK_I(CLK_I), .RST_I(RST_I), .AWADDR_I(AWADDR_I),
		.AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I),
		.WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
		.BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
		.ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
		.RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
		.RREADY_I(RREADY_I), .BANK_I(BANK_I),
		.GEN_REG_ROW_SELECT_I(GEN_REG_ROW_SELECT_I), .REQ_I(REQ_I),
		.RES_O(RES_O), .GEN_REG_ADDR_O(GEN_REG_ADDR_O),
		.ADD_RESULT_TO_R_O(ADD_RESULT_TO_R_O)
	);

	initial begin
		CLK_I = 1'b0;
		forever #50 CLK_I = ~CLK_I;
	end

	task automatic give_verdict();
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// readiness is judged at the falling edge so the comb ready never races
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ah, wh;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge CLK_I);
		AWADDR_I <= a;
		WDATA_I <= d;
		AWVALID_I <= 1'b1;
		WVALID_I <= 1'b1;
		BREADY_I <= 1'b1;
		while (pa || pw) begin
			@(negedge CLK_I);
			ah = pa && AWREADY_O;
			wh = pw && WREADY_O;
			@(posedge CLK_I);
			if (ah) begin
				AWVALID_I <= 1'b0;
				pa = 1'b0;
			end
			if (wh) begin
				WVALID_I <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(negedge CLK_I); while (BVALID_O !== 1'b1);
		@(posedge CLK_I);
		rs = BRESP_O;
		BREADY_I <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge CLK_I);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		RREADY_I <= 1'b1;
		do @(negedge CLK_I); while (ARREADY_O !== 1'b1);
		@(posedge CLK_I);
		ARVALID_I <= 1'b0;
		do @(negedge CLK_I); while (RVALID_O !== 1'b1);
		@(posedge CLK_I);
		rd = RDATA_O;
		rs = RRESP_O;
		RREADY_I <= 1'b0;
	endtask

	// one request, result one cycle later, standing for one cycle only
	task automatic rq(input logic [1:0] k, input logic [10:0] m,
		input logic [3:0] g, input logic [10:0] ed, input logic [10:0] ei);
		@(posedge CLK_I);
		BANK_I <= m[10:7];
		REQ_I <= '{1'b1, k, m[6:4], m[3:0], g};
		@(posedge CLK_I);
		REQ_I.valid <= 1'b0;
		#1;
		chk(32'(RES_O.valid), 32'h1);
		chk(32'(RES_O.direct), 32'(ed));
		chk(32'(ADD_RESULT_TO_R_O), 32'(k == 2'h0));
		chk(32'(GEN_REG_ADDR_O), {21'h0, m[10:7], 3'h2, m[3:0]});
		chk(32'(RES_O.ind_used), 32'(k == 2'h1 || k == 2'h2));
		if (k == 2'h1 || k == 2'h2) begin
			chk(32'(RES_O.indirect), 32'(ei));
		end
		@(posedge CLK_I);
		#1;
		chk(32'(RES_O.valid), 32'h0);
	endtask

	task automatic t_regs();
		chk(32'(RES_O), 32'h0);
		axr(OFF_INDEX);
		chk(rd, 32'h0);
		axw(OFF_INDEX, 32'hffffffff);
		chk(32'(rs), 32'(RESP_OKAY));
		axr(OFF_INDEX);
		chk(rd, 32'h7ff);
		axw(OFF_PTR, 32'hffffffff);
		axr(OFF_PTR);
		chk(rd, 32'h7f);
		axw(8'h10, 32'h1);
		chk(32'(rs), 32'(RESP_SLVERR));
		axr(8'h10);
		chk(32'(rs), 32'(RESP_SLVERR));
	endtask

	// index and pointer left all ones: plain mode must ignore both
	task automatic t_plain();
		axw(OFF_CTRL, 32'h0);
		rq(2'h0, 11'h2e1, 4'h3, 11'h2e1, 11'h0);
		rq(2'h1, 11'h034, 4'h8, 11'h034, 11'h038);
		rq(2'h2, 11'h034, 4'he, 11'h034, 11'h03e);
		rq(2'h3, 11'h034, 4'h8, 11'h034, 11'h0);
	endtask

	task automatic t_diag();
		axw(OFF_INDEX, 32'h0);
		axw(OFF_PTR, 32'h16);
		axw(OFF_CTRL, 32'h2);
		rq(2'h1, 11'h034, 4'h8, 11'h034, 11'h168);
		rq(2'h2, 11'h1b4, 4'he, 11'h1b4, 11'h16e);
		rq(2'h0, 11'h034, 4'h0, 11'h034, 11'h0);
		// the prohibited pair must leave only the pointer enable set
		axw(OFF_CTRL, 32'h3);
		axr(OFF_CTRL);
		chk(rd, 32'h2);
	endtask

	task automatic t_index();
		axw(OFF_CTRL, 32'h1);
		axw(OFF_INDEX, 32'h12);
		rq(2'h0, 11'h061, 4'h3, 11'h073, 11'h0);
		axw(OFF_INDEX, 32'h101);
		rq(2'h1, 11'h034, 4'h8, 11'h135, 11'h138);
		rq(2'h2, 11'h034, 4'he, 11'h135, 11'h13e);
		axw(OFF_INDEX, 32'h100);
		rq(2'h0, 11'h07f, 4'h0, 11'h07f, 11'h0);
		axw(OFF_CTRL, 32'h0);
		rq(2'h0, 11'h061, 4'h0, 11'h061, 11'h0);
		axr(OFF_STATUS);
		chk(rd, 32'h061);
	endtask

	initial begin
		n_fail = 0;
		num_checks = 0;
		RST_I = 1'b1;
		AWADDR_I = 8'h00;
		ARADDR_I = 8'h00;
		AWVALID_I = 1'b0;
		WVALID_I = 1'b0;
		BREADY_I = 1'b0;
		ARVALID_I = 1'b0;
		RREADY_I = 1'b0;
		WDATA_I = 32'h0;
		WSTRB_I = 4'hf;
		BANK_I = 4'h0;
		GEN_REG_ROW_SELECT_I = 3'h2;
		REQ_I = '0;
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		t_regs();
		t_plain();
		t_diag();
		t_index();
		give_verdict();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge CLK_I);
		n_fail++;
		give_verdict();
	end
endmodule
